// file: shared/urx_pkg.sv
// constants for the receive control block and its baud generator
package urx_pkg;

    // register indices on the plain register port
    localparam logic [1:0] URX_ADDR_RCV_CTRL = 2'h0;
    localparam logic [1:0] URX_ADDR_XMT_CTRL = 2'h1;
    localparam logic [1:0] URX_ADDR_DIVISOR = 2'h2;
    localparam logic [1:0] URX_ADDR_RX_BUF = 2'h3;

    // receive_status_control field positions
    localparam int unsigned URX_BIT_PORT_EN = 7;
    localparam int unsigned URX_BIT_NINE_SEL = 6;
    localparam int unsigned URX_BIT_SINGLE_EN = 5;
    localparam int unsigned URX_BIT_CONT_EN = 4;
    localparam int unsigned URX_BIT_ADDR_DET = 3;
    localparam int unsigned URX_BIT_FRAME_ERR = 2;
    localparam int unsigned URX_BIT_OVERRUN = 1;
    localparam int unsigned URX_BIT_NINTH = 0;

    // transmit_status_control field positions
    localparam int unsigned URX_BIT_MASTER = 7;
    localparam int unsigned URX_BIT_SYNC_MODE = 4;
    localparam int unsigned URX_BIT_HIGH_SPEED = 2;

    // writable bits and values after reset
    localparam logic [7:0] URX_RCV_CTRL_WMASK = 8'hF8;
    localparam logic [7:0] URX_XMT_CTRL_WMASK = 8'hF5;
    localparam logic [7:0] URX_RCV_CTRL_RST = 8'h00;
    localparam logic [7:0] URX_XMT_CTRL_RST = 8'h02;
    localparam logic [7:0] URX_DIVISOR_RST = 8'h00;
    localparam logic [8:0] URX_SHIFT_RST = 9'h000;

    // async: 16 samples per bit, majority of samples 7, 8 and 9
    localparam logic [3:0] URX_SAMPLE_A = 4'h7;
    localparam logic [3:0] URX_SAMPLE_B = 4'h8;
    localparam logic [3:0] URX_SAMPLE_C = 4'h9;
    localparam logic [3:0] URX_SAMPLE_LAST = 4'hF;
    // low speed: one sample tick every fourth baud tick (16 x 4 = 64)
    localparam logic [1:0] URX_LOW_PRESCALE_LAST = 2'h3;
    // sync master: four baud ticks per bit clock
    localparam logic [1:0] URX_SYNC_RISE_PHASE = 2'h1;
    localparam logic [1:0] URX_SYNC_FALL_PHASE = 2'h3;
    // character lengths in bits
    localparam logic [3:0] URX_LEN_EIGHT = 4'h8;
    localparam logic [3:0] URX_LEN_NINE = 4'h9;

    // receiver sequencer states
    typedef enum logic [2:0] {
        URX_IDLE,
        URX_START,
        URX_DATA,
        URX_STOP,
        URX_SYNC
    } urx_state_t;

endpackage

// file: shared/urx_baud_if.sv
`timescale 1ns/1ps
`default_nettype none
// link between the receive controller and its baud timer
interface urx_baud_if;
    logic [7:0] divisor;
    logic restart;
    logic tick;

    modport gen (input divisor, input restart, output tick);
    modport user (output divisor, output restart, input tick);
endinterface
`default_nettype wire

// file: core/urx_baud_gen.sv
`timescale 1ns/1ps
`default_nettype none
// free-running 8-bit down counter, one tick every divisor+1 clocks
module urx_baud_gen
    import urx_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // divisor, restart and tick
    urx_baud_if.gen bif
);
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;

    // reload on every tick; a restart clears the period in progress
    always_comb begin
        bif.tick = (cnt_reg == 8'h00) && !bif.restart;
        if (bif.restart) begin
            cnt_next = bif.divisor;
        end else if (cnt_reg == 8'h00) begin
            cnt_next = bif.divisor;
        end else begin
            cnt_next = cnt_reg - 8'h01;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_reg <= URX_DIVISOR_RST;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule // urx_baud_gen
`default_nettype wire

// file: core/urx_rx_ctrl.sv
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module urx_rx_ctrl
    import urx_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // register port
    input wire logic [1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // serial pins
    input wire logic i_rx_data_pin,
    input wire logic i_clk_pin_in,
    output logic o_clk_pin_out,
    output logic o_clk_pin_oe,
    // receive buffer holds a character
    output logic o_rx_ready
);
    // registers and their next values
    logic [7:0] rcv_ctrl_reg, rcv_ctrl_next;
    logic [7:0] xmt_ctrl_reg, xmt_ctrl_next;
    logic [7:0] divisor_reg, divisor_next;
    logic [7:0] rx_buf_reg, rx_buf_next;
    logic buf_full_reg, buf_full_next;
    logic [7:0] rdata_reg, rdata_next;
    logic restart_reg, restart_next;
    urx_state_t state_reg, state_next;
    logic [8:0] shift_reg, shift_next;
    logic [3:0] bit_cnt_reg, bit_cnt_next;
    logic [3:0] samp_cnt_reg, samp_cnt_next;
    logic [1:0] presc_reg, presc_next;
    logic [1:0] phase_reg, phase_next;
    logic samp_a_reg, samp_a_next;
    logic samp_b_reg, samp_b_next;
    logic clk_out_reg, clk_out_next;
    logic ext_clk_prev_reg, ext_clk_prev_next;

    // pin synchronisers
    logic data_meta_reg, data_sync_reg;
    logic clk_meta_reg, clk_sync_reg;

    // decoded controls
    logic port_en, nine_sel, single_en, cont_en, addr_det, overrun;
    logic sync_mode, master, high_speed;
    logic rx_on, samp_tick, vote, buf_read;
    logic char_done, frame_ok, keep_char, full_eff;
    logic [8:0] char_data, char_view;
    logic [3:0] char_len;

    urx_baud_if bif ();

    urx_baud_gen u_baud (
        .i_sys_clk (i_sys_clk),
        .i_rst (i_rst),
        .bif (bif)
    );

    // baud timer hookup; restart follows a divisor write by one cycle
    assign bif.divisor = divisor_reg;
    assign bif.restart = restart_reg;

    // field decode
    assign port_en = rcv_ctrl_reg[URX_BIT_PORT_EN];
    assign nine_sel = rcv_ctrl_reg[URX_BIT_NINE_SEL];
    assign single_en = rcv_ctrl_reg[URX_BIT_SINGLE_EN];
    assign cont_en = rcv_ctrl_reg[URX_BIT_CONT_EN];
    assign addr_det = rcv_ctrl_reg[URX_BIT_ADDR_DET];
    assign overrun = rcv_ctrl_reg[URX_BIT_OVERRUN];
    assign sync_mode = xmt_ctrl_reg[URX_BIT_SYNC_MODE];
    assign master = xmt_ctrl_reg[URX_BIT_MASTER];
    assign high_speed = xmt_ctrl_reg[URX_BIT_HIGH_SPEED];

    // outputs
    assign o_rdata = rdata_reg;
    assign o_rx_ready = buf_full_reg;
    assign o_clk_pin_out = clk_out_reg;
    assign o_clk_pin_oe = port_en && sync_mode && master;

    // receiver runs only with the port on and no pending overrun
    always_comb begin
        if (!port_en || overrun) begin
            rx_on = 1'b0;
        end else if (sync_mode && master) begin
            rx_on = cont_en || single_en;
        end else begin
            rx_on = cont_en;
        end
    end

    // sample tick: every baud tick at high speed, every fourth at low
    assign samp_tick = bif.tick && (high_speed || (presc_reg == URX_LOW_PRESCALE_LAST));
    // majority of three samples around mid-bit
    assign vote = (samp_a_reg & samp_b_reg) | (samp_a_reg & data_sync_reg)
        | (samp_b_reg & data_sync_reg);
    assign char_len = nine_sel ? URX_LEN_NINE : URX_LEN_EIGHT;
    assign buf_read = i_rd && (i_addr == URX_ADDR_RX_BUF);
    assign full_eff = buf_full_reg && !buf_read;
    assign char_view = (state_reg == URX_SYNC && !master) ? {data_sync_reg, shift_reg[8:1]}
        : shift_reg; // a slave takes its last bit in the done cycle

    // pin synchronisers: two flops before any logic
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            data_meta_reg <= 1'b1;
            data_sync_reg <= 1'b1;
            clk_meta_reg <= 1'b0;
            clk_sync_reg <= 1'b0;
        end else begin
            data_meta_reg <= i_rx_data_pin;
            data_sync_reg <= data_meta_reg;
            clk_meta_reg <= i_clk_pin_in;
            clk_sync_reg <= clk_meta_reg;
        end
    end

    // next values for registers, receiver sequencer and sync clock
    always_comb begin
        rcv_ctrl_next = rcv_ctrl_reg;
        xmt_ctrl_next = xmt_ctrl_reg;
        divisor_next = divisor_reg;
        rx_buf_next = rx_buf_reg;
        buf_full_next = buf_full_reg;
        rdata_next = 8'h00;
        restart_next = 1'b0;
        state_next = state_reg;
        shift_next = shift_reg;
        bit_cnt_next = bit_cnt_reg;
        samp_cnt_next = samp_cnt_reg;
        presc_next = presc_reg;
        phase_next = phase_reg;
        samp_a_next = samp_a_reg;
        samp_b_next = samp_b_reg;
        clk_out_next = clk_out_reg;
        ext_clk_prev_next = clk_sync_reg;
        char_done = 1'b0;
        frame_ok = 1'b1;
        char_data = URX_SHIFT_RST;
        keep_char = 1'b0;

        // low speed prescaler, cleared with the baud timer
        if (restart_reg) begin
            presc_next = 2'h0;
        end else if (bif.tick) begin
            presc_next = presc_reg + 2'h1;
        end

        // receiver sequencer
        unique case (state_reg)
            URX_IDLE: begin
                clk_out_next = 1'b0;
                phase_next = 2'h0;
                bit_cnt_next = 4'h0;
                samp_cnt_next = 4'h0;
                if (rx_on && sync_mode) begin
                    state_next = URX_SYNC;
                end else if (rx_on && !data_sync_reg) begin
                    state_next = URX_START; // falling edge of start bit
                end
            end
            URX_START, URX_DATA, URX_STOP: begin
                if (samp_tick) begin
                    samp_cnt_next = samp_cnt_reg + 4'h1;
                    if (samp_cnt_reg == URX_SAMPLE_A) begin
                        samp_a_next = data_sync_reg;
                    end
                    if (samp_cnt_reg == URX_SAMPLE_B) begin
                        samp_b_next = data_sync_reg;
                    end
                    if (samp_cnt_reg == URX_SAMPLE_C) begin
                        if (state_reg == URX_START) begin
                            if (vote) begin
                                state_next = URX_IDLE; // false start
                            end
                        end else if (state_reg == URX_DATA) begin
                            shift_next = {vote, shift_reg[8:1]}; // lsb first
                            bit_cnt_next = bit_cnt_reg + 4'h1;
                        end else begin
                            char_done = 1'b1;
                            frame_ok = vote;
                            state_next = URX_IDLE;
                        end
                    end
                    if (samp_cnt_reg == URX_SAMPLE_LAST) begin
                        if (state_reg == URX_START) begin
                            state_next = URX_DATA;
                        end else if (bit_cnt_reg == char_len) begin
                            state_next = URX_STOP;
                        end
                    end
                end
            end
            URX_SYNC: begin
                if (master) begin
                    // bit clock: four baud ticks per period, sample on rise
                    if (bif.tick) begin
                        phase_next = phase_reg + 2'h1;
                        if (phase_reg == URX_SYNC_RISE_PHASE) begin
                            clk_out_next = 1'b1;
                            shift_next = {data_sync_reg, shift_reg[8:1]};
                            bit_cnt_next = bit_cnt_reg + 4'h1;
                        end
                        if (phase_reg == URX_SYNC_FALL_PHASE) begin
                            clk_out_next = 1'b0;
                            if (bit_cnt_reg == char_len) begin
                                char_done = 1'b1;
                                bit_cnt_next = 4'h0;
                            end
                        end
                    end
                end else if (clk_sync_reg && !ext_clk_prev_reg) begin
                    // slave: rising edge of the outside clock
                    shift_next = {data_sync_reg, shift_reg[8:1]};
                    bit_cnt_next = bit_cnt_reg + 4'h1;
                    if (bit_cnt_reg + 4'h1 == char_len) begin
                        char_done = 1'b1;
                        bit_cnt_next = 4'h0;
                    end
                end
                // a finished single receive in master mode ends here
                if (char_done && master && !cont_en) begin
                    rcv_ctrl_next[URX_BIT_SINGLE_EN] = 1'b0;
                    state_next = URX_IDLE;
                end
            end
            default: begin
                state_next = URX_IDLE;
            end
        endcase

        // abort when the receiver is switched off or the mode changes
        if (!rx_on || (sync_mode != (state_reg == URX_SYNC) && state_reg != URX_IDLE)) begin
            state_next = URX_IDLE;
            clk_out_next = 1'b0;
        end

        // align the character and decide whether to keep it
        if (char_done) begin
            shift_next = URX_SHIFT_RST;
        end
        char_data = nine_sel ? char_view : {1'b0, char_view[8:1]};
        keep_char = !(addr_det && nine_sel && !sync_mode && !char_data[8]);

        // buffer load or overrun on a kept character
        if (buf_read) begin
            buf_full_next = 1'b0;
        end
        if (char_done && keep_char) begin
            if (full_eff) begin
                rcv_ctrl_next[URX_BIT_OVERRUN] = 1'b1;
            end else begin
                rx_buf_next = char_data[7:0];
                buf_full_next = 1'b1;
                rcv_ctrl_next[URX_BIT_NINTH] = char_data[8];
                rcv_ctrl_next[URX_BIT_FRAME_ERR] = !frame_ok;
            end
        end

        // software writes; overrun clears when continuous enable is clear
        if (i_wr) begin
            unique case (i_addr)
                URX_ADDR_RCV_CTRL: begin
                    rcv_ctrl_next = (i_wdata & URX_RCV_CTRL_WMASK)
                        | (rcv_ctrl_next & ~URX_RCV_CTRL_WMASK);
                end
                URX_ADDR_XMT_CTRL: begin
                    xmt_ctrl_next = (i_wdata & URX_XMT_CTRL_WMASK)
                        | (URX_XMT_CTRL_RST & ~URX_XMT_CTRL_WMASK);
                end
                URX_ADDR_DIVISOR: begin
                    divisor_next = i_wdata;
                    restart_next = 1'b1;
                end
                URX_ADDR_RX_BUF: begin
                end
            endcase
        end
        if (!rcv_ctrl_next[URX_BIT_CONT_EN] && !(char_done && keep_char && full_eff)) begin
            rcv_ctrl_next[URX_BIT_OVERRUN] = 1'b0;
        end

        // read data, valid only in the cycle after the strobe
        if (i_rd) begin
            unique case (i_addr)
                URX_ADDR_RCV_CTRL: rdata_next = rcv_ctrl_reg;
                URX_ADDR_XMT_CTRL: rdata_next = xmt_ctrl_reg;
                URX_ADDR_DIVISOR: rdata_next = divisor_reg;
                URX_ADDR_RX_BUF: rdata_next = rx_buf_reg;
            endcase
        end
    end

    // register stage for everything above
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            rcv_ctrl_reg <= URX_RCV_CTRL_RST;
            xmt_ctrl_reg <= URX_XMT_CTRL_RST;
            divisor_reg <= URX_DIVISOR_RST;
            rx_buf_reg <= 8'h00;
            buf_full_reg <= 1'b0;
            rdata_reg <= 8'h00;
            restart_reg <= 1'b0;
            state_reg <= URX_IDLE;
            shift_reg <= URX_SHIFT_RST;
            bit_cnt_reg <= 4'h0;
            samp_cnt_reg <= 4'h0;
            presc_reg <= 2'h0;
            phase_reg <= 2'h0;
            samp_a_reg <= 1'b1;
            samp_b_reg <= 1'b1;
            clk_out_reg <= 1'b0;
            ext_clk_prev_reg <= 1'b0;
        end else begin
            rcv_ctrl_reg <= rcv_ctrl_next;
            xmt_ctrl_reg <= xmt_ctrl_next;
            divisor_reg <= divisor_next;
            rx_buf_reg <= rx_buf_next;
            buf_full_reg <= buf_full_next;
            rdata_reg <= rdata_next;
            restart_reg <= restart_next;
            state_reg <= state_next;
            shift_reg <= shift_next;
            bit_cnt_reg <= bit_cnt_next;
            samp_cnt_reg <= samp_cnt_next;
            presc_reg <= presc_next;
            phase_reg <= phase_next;
            samp_a_reg <= samp_a_next;
            samp_b_reg <= samp_b_next;
            clk_out_reg <= clk_out_next;
            ext_clk_prev_reg <= ext_clk_prev_next;
        end
    end
endmodule // urx_rx_ctrl
`default_nettype wire

// file: dv/urx_rx_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checks of the receive controller
module urx_rx_ctrl_properties
    import urx_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // register port
    input wire logic [1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // pins
    input wire logic i_rx_data_pin,
    input wire logic i_clk_pin_in,
    input wire logic o_clk_pin_out,
    input wire logic o_clk_pin_oe,
    input wire logic o_rx_ready
);
    logic [7:0] rcv_reg;
    logic [7:0] xmt_reg;
    logic [7:0] div_reg;
    logic [9:0] run_reg;
    logic pin_reg;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // shadow of software writes and run length of the clock pin level
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            rcv_reg <= URX_RCV_CTRL_RST;
            xmt_reg <= URX_XMT_CTRL_RST;
            div_reg <= URX_DIVISOR_RST;
            run_reg <= 10'h001;
            pin_reg <= 1'b0;
        end else begin
            if (i_wr && i_addr == URX_ADDR_RCV_CTRL) rcv_reg <= i_wdata;
            if (i_wr && i_addr == URX_ADDR_XMT_CTRL) xmt_reg <= i_wdata;
            if (i_wr && i_addr == URX_ADDR_DIVISOR) div_reg <= i_wdata;
            pin_reg <= o_clk_pin_out;
            run_reg <= (o_clk_pin_out != pin_reg) ? 10'h001 : run_reg + 10'h001;
        end
    end
    // a read strobe at one register index
    sequence s_read(logic [1:0] a);
        i_rd && i_addr == a;
    endsequence
    a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data not idle");
    a_rd_ctrl: assert property (s_read(URX_ADDR_RCV_CTRL) |=>
        o_rdata[7:6] == rcv_reg[7:6] && o_rdata[4:3] == rcv_reg[4:3])
        else $error("control read wrong");
    a_rd_xmt: assert property (s_read(URX_ADDR_XMT_CTRL) |=>
        o_rdata == ((xmt_reg & URX_XMT_CTRL_WMASK) | 8'h02)) else $error("xmt read wrong");
    a_rd_divisor: assert property (s_read(URX_ADDR_DIVISOR) |=> o_rdata == div_reg)
        else $error("divisor read wrong");
    a_clk_oe: assert property (o_clk_pin_oe == (rcv_reg[7] && xmt_reg[4] && xmt_reg[7]))
        else $error("clock pin enable wrong");
    a_clk_high: assert property ($fell(o_clk_pin_out) |->
        run_reg == ({2'b00, div_reg} + 10'h001) * 10'h002) else $error("clock high time wrong");
    a_ready_hold: assert property (o_rx_ready && !i_rd && !i_wr |=> o_rx_ready)
        else $error("ready dropped");
    a_ready_port: assert property ($rose(o_rx_ready) |-> rcv_reg[7])
        else $error("ready while port off");
endmodule // urx_rx_ctrl_properties
bind urx_rx_ctrl urx_rx_ctrl_properties u_props (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_rx_data_pin(i_rx_data_pin), .i_clk_pin_in(i_clk_pin_in),
    .o_clk_pin_out(o_clk_pin_out), .o_clk_pin_oe(o_clk_pin_oe), .o_rx_ready(o_rx_ready));
`default_nettype wire

// file: dv/urx_far_end.sv
`timescale 1ns/1ps
`default_nettype none
// far-end partner: async transmitter and sync slave data source
module urx_far_end (
    // clock and pins
    input wire logic i_sys_clk,
    input wire logic i_clk_pin,
    output logic o_data
);
    initial o_data = 1'b1;
    // async frame: start low, data lsb first, stop level, then idle high
    task automatic send_async(input logic [8:0] d, input int nbits, input logic stop,
                              input int bit_clks);
        o_data <= 1'b0;
        repeat (bit_clks) @(posedge i_sys_clk);
        for (int i = 0; i < nbits; i++) begin
            o_data <= d[i];
            repeat (bit_clks) @(posedge i_sys_clk);
        end
        o_data <= stop;
        repeat (bit_clks) @(posedge i_sys_clk);
        o_data <= 1'b1;
        @(posedge i_sys_clk); // at least one idle clock before the next start
    endtask
    // bounded wait for a clock pin level, just after a system edge
    task automatic wait_pin(input logic v, inout logic ok);
        int n;
        n = 0;
        while (i_clk_pin !== v && n < 2000) begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end
        if (n == 2000) ok = 1'b0;
    endtask
    // sync data: next bit after each falling clock, line released high at the end
    task automatic send_sync(input logic [7:0] d, output logic ok);
        ok = 1'b1;
        o_data <= d[0];
        for (int i = 1; i <= 8; i++) begin
            wait_pin(1'b1, ok);
            wait_pin(1'b0, ok);
            o_data <= (i < 8) ? d[i] : 1'b1;
        end
    endtask
endmodule // urx_far_end
`default_nettype wire

// file: dv/urx_rx_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the receive controller
module urx_rx_ctrl_bench
    import urx_pkg::*;
;
    logic i_sys_clk = 1'b0;
    logic i_rst;
    logic [1:0] i_addr;
    logic [7:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [7:0] o_rdata;
    logic rx_line;
    logic o_clk_pin_out;
    logic o_clk_pin_oe;
    logic o_rx_ready;
    logic ok;
    logic slv_clk = 1'b0;
    int n_fail = 0;
    int n_tests = 0;
    // 25 MHz system clock
    always #20 i_sys_clk = ~i_sys_clk;
    urx_rx_ctrl uut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_rx_data_pin(rx_line), .i_clk_pin_in(slv_clk), .o_clk_pin_out(o_clk_pin_out),
        .o_clk_pin_oe(o_clk_pin_oe), .o_rx_ready(o_rx_ready));
    urx_far_end far (.i_sys_clk(i_sys_clk), .i_clk_pin(o_clk_pin_oe ? o_clk_pin_out : slv_clk),
        .o_data(rx_line));
    // compare and count
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // register write and read cycles
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] mask, input logic [7:0] exp);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1 chk({1'b0, o_rdata & mask}, {1'b0, exp});
    endtask
    // bounded wait for the ready flag, then compare it
    task automatic wait_rdy(input logic want);
        int n;
        n = 0;
        while (o_rx_ready !== 1'b1 && n < 3000) begin
            @(posedge i_sys_clk);
            n++;
        end
        chk({8'h00, o_rx_ready}, {8'h00, want});
        if (want && o_rx_ready !== 1'b1) end_sim;
    endtask
    task automatic t_regs;
        rd(URX_ADDR_RCV_CTRL, 8'hFE, 8'h00);
        rd(URX_ADDR_XMT_CTRL, 8'hFF, 8'h02);
        rd(URX_ADDR_DIVISOR, 8'hFF, 8'h00);
        wr(URX_ADDR_RCV_CTRL, 8'h06);
        rd(URX_ADDR_RCV_CTRL, 8'hFE, 8'h00);
        wr(URX_ADDR_DIVISOR, 8'hFF);
        rd(URX_ADDR_DIVISOR, 8'hFF, 8'hFF);
        $display("done regs");
    endtask
    // byte at low then high speed, divisor 1: 128 and 32 clocks a bit
    task automatic t_async;
        for (int m = 0; m < 2; m++) begin
            wr(URX_ADDR_XMT_CTRL, m ? 8'h04 : 8'h00);
            wr(URX_ADDR_DIVISOR, 8'h01);
            wr(URX_ADDR_RCV_CTRL, 8'h90);
            far.send_async({1'b0, 8'h5A ^ {8{m[0]}}}, 8, 1'b1, m ? 32 : 128);
            wait_rdy(1'b1);
            rd(URX_ADDR_RX_BUF, 8'hFF, 8'h5A ^ {8{m[0]}});
        end
        $display("done async");
    endtask
    // bad stop bit, then a good character clears the flag
    task automatic t_framing_error_flag;
        far.send_async(9'h033, 8, 1'b0, 32);
        wait_rdy(1'b1);
        rd(URX_ADDR_RCV_CTRL, 8'hFE, 8'h94);
        rd(URX_ADDR_RX_BUF, 8'hFF, 8'h33);
        far.send_async(9'h0C3, 8, 1'b1, 32);
        wait_rdy(1'b1);
        rd(URX_ADDR_RX_BUF, 8'hFF, 8'hC3);
        rd(URX_ADDR_RCV_CTRL, 8'hFE, 8'h90);
        $display("done framing_error_flag");
    endtask
    // nine-bit characters with and without address detection
    task automatic t_nine;
        wr(URX_ADDR_RCV_CTRL, 8'hD8);
        far.send_async(9'h03C, 9, 1'b1, 32);
        wait_rdy(1'b0);
        far.send_async(9'h1C3, 9, 1'b1, 32);
        wait_rdy(1'b1);
        rd(URX_ADDR_RCV_CTRL, 8'h07, 8'h01);
        rd(URX_ADDR_RX_BUF, 8'hFF, 8'hC3);
        wr(URX_ADDR_RCV_CTRL, 8'hD0);
        far.send_async(9'h03C, 9, 1'b1, 32);
        wait_rdy(1'b1);
        rd(URX_ADDR_RCV_CTRL, 8'h07, 8'h00);
        rd(URX_ADDR_RX_BUF, 8'hFF, 8'h3C);
        $display("done nine");
    endtask
    // overrun, cleared by dropping continuous enable; receiver then off
    task automatic t_over;
        wr(URX_ADDR_RCV_CTRL, 8'h90);
        far.send_async(9'h011, 8, 1'b1, 32);
        wait_rdy(1'b1);
        far.send_async(9'h022, 8, 1'b1, 32);
        rd(URX_ADDR_RCV_CTRL, 8'h02, 8'h02);
        wr(URX_ADDR_RCV_CTRL, 8'h80);
        rd(URX_ADDR_RCV_CTRL, 8'h02, 8'h00);
        rd(URX_ADDR_RX_BUF, 8'hFF, 8'h11);
        far.send_async(9'h044, 8, 1'b1, 32);
        wait_rdy(1'b0);
        $display("done overrun");
    endtask
    // sync master single receive, enable clears itself
    task automatic t_sync;
        wr(URX_ADDR_XMT_CTRL, 8'h94);
        #1 chk({8'h00, o_clk_pin_oe}, 9'h001);
        fork
            far.send_sync(8'hC6, ok);
            wr(URX_ADDR_RCV_CTRL, 8'hA0);
        join
        chk({8'h00, ok}, 9'h001);
        if (!ok) end_sim;
        wait_rdy(1'b1);
        rd(URX_ADDR_RCV_CTRL, 8'hFE, 8'h80);
        rd(URX_ADDR_RX_BUF, 8'hFF, 8'hC6);
        $display("done sync");
    endtask
    // sync slave, bit clock from the bench, continuous receive
    task automatic t_slave;
        wr(URX_ADDR_XMT_CTRL, 8'h10);
        wr(URX_ADDR_RCV_CTRL, 8'h90);
        fork
            far.send_sync(8'h3B, ok);
            repeat (16) begin
                repeat (8) @(posedge i_sys_clk);
                slv_clk <= ~slv_clk;
            end
        join
        chk({8'h00, ok}, 9'h001);
        if (!ok) end_sim;
        wait_rdy(1'b1);
        rd(URX_ADDR_RX_BUF, 8'hFF, 8'h3B);
        wr(URX_ADDR_RCV_CTRL, 8'h80);
        $display("done slave");
    endtask
    // verdict
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // reset for 5 cycles, then the scenarios
    initial begin
        i_rst = 1'b1;
        i_addr = 2'h0;
        i_wdata = 8'h00;
        i_wr = 1'b0;
        i_rd = 1'b0;
        repeat (5) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        t_regs;
        t_async;
        t_framing_error_flag;
        t_nine;
        t_over;
        t_sync;
        t_slave;
        end_sim;
    end
endmodule // urx_rx_ctrl_bench
`default_nettype wire
